// [src/dpwm_pkg.sv]
package dpwm_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam int         ADDR_W   = 5;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_RUN  = 5'h04;
  localparam logic [4:0] OFS_PIN  = 5'h08;
  localparam logic [4:0] OFS_CMPA = 5'h0c;
  localparam logic [4:0] OFS_CMPB = 5'h10;

  // ----------------------------------------
  // mode_and_clock_control fields
  // ----------------------------------------
  localparam int MODE_A_BIT = 7;
  localparam int MODE_B_BIT = 6;
  localparam int RES_A_BIT  = 5;
  localparam int RES_B_BIT  = 4;
  localparam int CLKA_LSB   = 2;
  localparam int CLKB_LSB   = 0;

  // ----------------------------------------
  // run_and_irq_control fields
  // ----------------------------------------
  localparam int RUN_A_BIT  = 7;
  localparam int RUN_B_BIT  = 6;
  localparam int CASC_BIT   = 5;
  localparam int FLAG_A_BIT = 3;
  localparam int FLAG_B_BIT = 2;
  localparam int IE_A_BIT   = 1;
  localparam int IE_B_BIT   = 0;

  // ----------------------------------------
  // pin_and_combine_control fields
  // ----------------------------------------
  localparam int PEN_B_BIT  = 6;
  localparam int PEN_A_BIT  = 5;
  localparam int COMB_BIT   = 4;

  // ----------------------------------------
  // reset values and counter limits
  // ----------------------------------------
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE  = 8'h01;
  localparam logic [7:0] MAX_8BIT = 8'hff;
  localparam logic [7:0] MAX_7BIT = 8'h7f;

  // ----------------------------------------
  // prescaler: one tap per count clock
  // ----------------------------------------
  localparam int         PRE_W    = 6;
  localparam logic [5:0] PRE_ZERO = 6'h00;
  localparam logic [5:0] PRE_ONE  = 6'h01;
  localparam logic [5:0] TAP_8    = 6'h07;
  localparam logic [5:0] TAP_16   = 6'h0f;
  localparam logic [5:0] TAP_64   = 6'h3f;

  typedef enum logic [1:0] {
    DPWM_DIV1,
    DPWM_DIV8,
    DPWM_DIV16,
    DPWM_DIV64
  } dpwm_clk_t;

endpackage

// [src/dpwm_timer.sv]
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module dpwm_timer (
  // clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [dpwm_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // general port side of the shared pins
  input  wire logic                       port_pin_a_dout_i,
  input  wire logic                       port_pin_a_dir_i,
  input  wire logic                       port_pin_b_dout_i,
  input  wire logic                       port_pin_b_dir_i,
  // shared pins
  output logic                            port_pin_a_o,
  output logic                            port_pin_a_oe_o,
  output logic                            port_pin_b_o,
  output logic                            port_pin_b_oe_o,
  // timer waves and interrupts
  output logic                            timer_out_a_o,
  output logic                            timer_out_b_o,
  output logic                            interrupt_line_a_o,
  output logic                            interrupt_line_b_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]          mode_and_clock_control_reg;
  logic [7:0]          run_and_irq_control_reg;
  logic [7:0]          pin_and_combine_control_reg;
  logic [7:0]          compare_value_a_reg;
  logic [7:0]          compare_value_b_reg;
  logic [7:0]          run_next;
  logic [31:0]         prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;
  logic [dpwm_pkg::PRE_W-1:0] pre_reg;
  logic [7:0]          cnt_reg   [2];
  logic [7:0]          latch_reg [2];
  logic [1:0]          out_reg;
  logic [1:0]          irq_reg;
  logic [1:0]          pin_reg;
  logic [1:0]          pin_oe_reg;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire       acc_w   = psel_i & penable_i;
  wire       done_w  = acc_w & pready_reg;
  wire       wr_w    = done_w & pwrite_i;
  wire       hit_mode = paddr_i == dpwm_pkg::OFS_MODE;
  wire       hit_run  = paddr_i == dpwm_pkg::OFS_RUN;
  wire       hit_pin  = paddr_i == dpwm_pkg::OFS_PIN;
  wire       hit_cmpa = paddr_i == dpwm_pkg::OFS_CMPA;
  wire       hit_cmpb = paddr_i == dpwm_pkg::OFS_CMPB;
  wire       mapped_w = hit_mode | hit_run | hit_pin | hit_cmpa
                      | hit_cmpb;
  wire [7:0] wdat_w  = pwdata_i[7:0];
  // compare registers read back as zero
  wire [7:0] rsel_w  = hit_mode ? mode_and_clock_control_reg :
                       hit_run  ? run_and_irq_control_reg :
                       hit_pin  ? pin_and_combine_control_reg :
                       dpwm_pkg::REG_RST;
  wire [31:0] rdata_w = {24'h000000, rsel_w};

  // ----------------------------------------
  // control bits per channel (0 = a, 1 = b)
  // ----------------------------------------
  wire       comb_w = pin_and_combine_control_reg[dpwm_pkg::COMB_BIT];
  wire       casc_w = run_and_irq_control_reg[dpwm_pkg::CASC_BIT];
  wire [1:0] run_w  = {run_and_irq_control_reg[dpwm_pkg::RUN_B_BIT],
                       run_and_irq_control_reg[dpwm_pkg::RUN_A_BIT]};
  wire [1:0] flag_w = {run_and_irq_control_reg[dpwm_pkg::FLAG_B_BIT],
                       run_and_irq_control_reg[dpwm_pkg::FLAG_A_BIT]};
  wire [1:0] ie_w   = {run_and_irq_control_reg[dpwm_pkg::IE_B_BIT],
                       run_and_irq_control_reg[dpwm_pkg::IE_A_BIT]};
  wire [1:0] pen_w  = {pin_and_combine_control_reg[dpwm_pkg::PEN_B_BIT],
                       pin_and_combine_control_reg[dpwm_pkg::PEN_A_BIT]};
  wire [1:0] mode_w = {mode_and_clock_control_reg[dpwm_pkg::MODE_B_BIT],
                       mode_and_clock_control_reg[dpwm_pkg::MODE_A_BIT]};
  wire [1:0] res_w  = {mode_and_clock_control_reg[dpwm_pkg::RES_B_BIT],
                       mode_and_clock_control_reg[dpwm_pkg::RES_A_BIT]};
  wire [1:0] csel_w [2];
  assign csel_w[0] = mode_and_clock_control_reg[dpwm_pkg::CLKA_LSB+:2];
  assign csel_w[1] = mode_and_clock_control_reg[dpwm_pkg::CLKB_LSB+:2];
  wire [7:0] cmp_w  [2];
  assign cmp_w[0] = compare_value_a_reg;
  assign cmp_w[1] = compare_value_b_reg;

  // ----------------------------------------
  // prescaler taps
  // ----------------------------------------
  wire       pre_run = |run_w;
  wire [3:0] tap_w   = {pre_reg == dpwm_pkg::TAP_64,
                        pre_reg[3:0] == dpwm_pkg::TAP_16[3:0],
                        pre_reg[2:0] == dpwm_pkg::TAP_8[2:0],
                        pre_run};

  // ----------------------------------------
  // per-channel counter, comparator, output
  // ----------------------------------------
  logic [1:0] tick_w;
  logic [1:0] match_w;
  logic [1:0] mt_w;
  logic [1:0] pwm_w;
  logic [1:0] set_w;
  // rising edge of the a square wave
  wire        a_rise = mt_w[0] & pen_w[0] & ~out_reg[0] & ~pwm_w[0];

  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam bit IS_A = (i == 0);

    // ----------------------------------------
    // count clock select
    // ----------------------------------------
    dpwm_pkg::dpwm_clk_t csel;
    assign csel = dpwm_pkg::dpwm_clk_t'(csel_w[i]);
    wire own_tick = csel == dpwm_pkg::DPWM_DIV1  ? tap_w[0] :
                    csel == dpwm_pkg::DPWM_DIV8  ? tap_w[1] :
                    csel == dpwm_pkg::DPWM_DIV16 ? tap_w[2] :
                    tap_w[3];
    wire cas = !IS_A && casc_w;
    assign tick_w[i] = run_w[i] & pre_run
                     & (cas ? a_rise : own_tick);

    // ----------------------------------------
    // comparator and counter
    // ----------------------------------------
    // compare writes only bite at the next zero
    wire [7:0] eff = cnt_reg[i] == dpwm_pkg::CNT_ZERO ? cmp_w[i]
                                                      : latch_reg[i];
    assign match_w[i] = cnt_reg[i] == eff;
    assign mt_w[i]    = tick_w[i] & match_w[i];
    assign pwm_w[i]   = mode_w[i] & ~comb_w;
    wire [7:0] top = res_w[i] ? dpwm_pkg::MAX_7BIT
                              : dpwm_pkg::MAX_8BIT;
    wire wrap = pwm_w[i] & (cnt_reg[i] == top);
    // a holds at its match until b closes the period
    wire hold = comb_w & IS_A & match_w[i];
    wire clr  = comb_w ? mt_w[1] : (~pwm_w[i] & mt_w[i]);
    wire [7:0] cnt_next =
        ~run_w[i] | clr ? dpwm_pkg::CNT_ZERO :
        ~tick_w[i] | hold ? cnt_reg[i] :
        wrap ? dpwm_pkg::CNT_ZERO :
        cnt_reg[i] + dpwm_pkg::CNT_ONE;

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    logic out_next;
    always_comb begin
      out_next = out_reg[i];
      if (comb_w) begin
        if (IS_A && mt_w[1]) begin
          out_next = 1'b0;
        end else if (IS_A && mt_w[0]) begin
          out_next = 1'b1;
        end
      end else if (pwm_w[i]) begin
        if (run_w[i] && match_w[i]) begin
          out_next = 1'b0;
        end else if (run_w[i] && cnt_reg[i] == dpwm_pkg::CNT_ZERO) begin
          out_next = 1'b1;
        end
      end else if (mt_w[i] && pen_w[i]) begin
        out_next = ~out_reg[i];
      end
    end

    // ----------------------------------------
    // flag set and counter registers
    // ----------------------------------------
    assign set_w[i] = mt_w[i] & (IS_A ? ~pwm_w[i] & ~comb_w
                                      : ~pwm_w[i]);
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_reg[i]   <= dpwm_pkg::CNT_ZERO;
        latch_reg[i] <= dpwm_pkg::CNT_ZERO;
        out_reg[i]   <= 1'b0;
      end else begin
        cnt_reg[i]   <= cnt_next;
        latch_reg[i] <= eff;
        out_reg[i]   <= out_next;
      end
    end

    // ----------------------------------------
    // shared pin mux
    // ----------------------------------------
    wire pin_next    = pen_w[i] ? out_next
                                : (IS_A ? port_pin_a_dout_i
                                        : port_pin_b_dout_i);
    wire pin_oe_next = pen_w[i] | (IS_A ? port_pin_a_dir_i
                                        : port_pin_b_dir_i);
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pin_reg[i]    <= 1'b0;
        pin_oe_reg[i] <= 1'b0;
        irq_reg[i]    <= 1'b0;
      end else begin
        pin_reg[i]    <= pin_next;
        pin_oe_reg[i] <= pin_oe_next;
        irq_reg[i]    <= (flag_w[i] | set_w[i]) & ie_w[i];
      end
    end
  end

  // ----------------------------------------
  // run_and_irq_control next value
  // ----------------------------------------
  always_comb begin
    run_next = run_and_irq_control_reg;
    if (wr_w && hit_run) begin
      run_next[dpwm_pkg::RUN_A_BIT] = wdat_w[dpwm_pkg::RUN_A_BIT];
      run_next[dpwm_pkg::RUN_B_BIT] = wdat_w[dpwm_pkg::RUN_B_BIT];
      run_next[dpwm_pkg::CASC_BIT]  = wdat_w[dpwm_pkg::CASC_BIT];
      run_next[dpwm_pkg::IE_A_BIT]  = wdat_w[dpwm_pkg::IE_A_BIT];
      run_next[dpwm_pkg::IE_B_BIT]  = wdat_w[dpwm_pkg::IE_B_BIT];
      run_next[dpwm_pkg::FLAG_A_BIT] = flag_w[0]
                                     & wdat_w[dpwm_pkg::FLAG_A_BIT];
      run_next[dpwm_pkg::FLAG_B_BIT] = flag_w[1]
                                     & wdat_w[dpwm_pkg::FLAG_B_BIT];
    end
    // set wins over a clearing write
    if (set_w[0]) begin
      run_next[dpwm_pkg::FLAG_A_BIT] = 1'b1;
    end
    if (set_w[1]) begin
      run_next[dpwm_pkg::FLAG_B_BIT] = 1'b1;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_and_clock_control_reg  <= dpwm_pkg::REG_RST;
      run_and_irq_control_reg     <= dpwm_pkg::REG_RST;
      pin_and_combine_control_reg <= dpwm_pkg::REG_RST;
      compare_value_a_reg         <= dpwm_pkg::REG_RST;
      compare_value_b_reg         <= dpwm_pkg::REG_RST;
    end else begin
      run_and_irq_control_reg <= run_next;
      if (wr_w && hit_mode) begin
        mode_and_clock_control_reg <= wdat_w;
      end
      if (wr_w && hit_pin) begin
        pin_and_combine_control_reg <= {1'b0, wdat_w[6:4], 4'h0};
      end
      if (wr_w && hit_cmpa) begin
        compare_value_a_reg <= wdat_w;
      end
      if (wr_w && hit_cmpb) begin
        compare_value_b_reg <= wdat_w;
      end
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // cleared while stopped so a start begins on a full tick
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_reg <= dpwm_pkg::PRE_ZERO;
    end else if (pre_run) begin
      pre_reg <= pre_reg + dpwm_pkg::PRE_ONE;
    end else begin
      pre_reg <= dpwm_pkg::PRE_ZERO;
    end
  end

  // ----------------------------------------
  // apb answer: one wait state
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= acc_w & ~pready_reg;
      // error only for an unmapped address
      pslverr_reg <= acc_w & ~pready_reg & ~mapped_w;
      if (acc_w && !pready_reg && !pwrite_i) begin
        prdata_reg <= rdata_w;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata_o           = prdata_reg;
  assign pready_o           = pready_reg;
  assign pslverr_o          = pslverr_reg;
  assign timer_out_a_o      = out_reg[0];
  assign timer_out_b_o      = out_reg[1];
  assign interrupt_line_a_o = irq_reg[0];
  assign interrupt_line_b_o = irq_reg[1];
  assign port_pin_a_o       = pin_reg[0];
  assign port_pin_a_oe_o    = pin_oe_reg[0];
  assign port_pin_b_o       = pin_reg[1];
  assign port_pin_b_oe_o    = pin_oe_reg[1];

endmodule

// [tb/dpwm_load.sv]
`timescale 1ns/1ps
module dpwm_load (
  // clock
  input  wire logic clk_sys_i,
  // loaded pin and its last full period
  input  wire logic pin_i,
  output int        hi_o = 0,
  output int        per_o = 0,
  output int        edges_o = 0
);
  logic last_reg = 1'b0;
  int   hc       = 0;
  int   pc       = 0;
  // ----------------------------------------
  // rise-to-rise high time and period
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    last_reg <= pin_i;
    pc       <= (pin_i && !last_reg) ? 1 : pc + 1;
    hc       <= (pin_i && !last_reg) ? 1 : hc + int'(pin_i);
    if (pin_i && !last_reg) begin
      hi_o    <= hc;
      per_o   <= pc;
      edges_o <= edges_o + 1;
    end
  end
endmodule

// [tb/dpwm_timer_props.sv]
`timescale 1ns/1ps
module dpwm_timer_chk (
  // clock, reset and apb
  input wire logic                          clk_sys_i,
  input wire logic                          nrst_i,
  input wire logic                          psel_i,
  input wire logic                          penable_i,
  input wire logic                          pwrite_i,
  input wire logic [dpwm_pkg::ADDR_W-1:0]   paddr_i,
  input wire logic [31:0]                   pwdata_i,
  input wire logic [31:0]                   prdata_o,
  input wire logic                          pready_o,
  input wire logic                          pslverr_o,
  // pins, waves and interrupts
  input wire logic                          port_pin_a_o,
  input wire logic                          port_pin_a_oe_o,
  input wire logic                          port_pin_b_oe_o,
  input wire logic                          timer_out_a_o,
  input wire logic                          timer_out_b_o,
  input wire logic                          interrupt_line_a_o,
  input wire logic                          interrupt_line_b_o
);
  // ----------------------------------------
  // register shadows from apb writes
  // ----------------------------------------
  logic [7:0] run_sh;
  logic [7:0] pin_sh;
  logic [7:0] mode_sh;
  wire logic  take_w = psel_i & penable_i & pready_o & pwrite_i;
  wire logic  pen_a  = pin_sh[dpwm_pkg::PEN_A_BIT];
  wire logic  pen_b  = pin_sh[dpwm_pkg::PEN_B_BIT];
  wire logic  comb   = pin_sh[dpwm_pkg::COMB_BIT];
  wire logic  ie_a   = run_sh[dpwm_pkg::IE_A_BIT];
  wire logic  ie_b   = run_sh[dpwm_pkg::IE_B_BIT];
  wire logic  idle   = !run_sh[dpwm_pkg::RUN_A_BIT]
                    && !run_sh[dpwm_pkg::RUN_B_BIT];
  wire logic  pwm_b  = mode_sh[dpwm_pkg::MODE_B_BIT];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_sh  <= 8'h00;
      pin_sh  <= 8'h00;
      mode_sh <= 8'h00;
    end else if (take_w) begin
      if (paddr_i == dpwm_pkg::OFS_RUN)  run_sh  <= pwdata_i[7:0];
      if (paddr_i == dpwm_pkg::OFS_PIN)  pin_sh  <= pwdata_i[7:0];
      if (paddr_i == dpwm_pkg::OFS_MODE) mode_sh <= pwdata_i[7:0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  a_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("apb answer out of step");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error flag without ready");
  a_cmp_rd_zero: assert property (
    psel_i && penable_i && pready_o && !pwrite_i && (paddr_i ==
    dpwm_pkg::OFS_CMPA || paddr_i == dpwm_pkg::OFS_CMPB) |-> prdata_o == 32'h0)
    else $error("compare register read not zero");
  a_pin_a_wave: assert property (pen_a && $past(pen_a) |->
    port_pin_a_oe_o && port_pin_a_o == timer_out_a_o)
    else $error("pin a not driven by timer");
  a_pin_b_oe: assert property (pen_b && $past(pen_b) |-> port_pin_b_oe_o)
    else $error("pin b not driven");
  a_irq_a_mask: assert property (!ie_a && !$past(ie_a) |-> !interrupt_line_a_o)
    else $error("interrupt a while disabled");
  a_irq_b_mask: assert property (!ie_b && !$past(ie_b) |-> !interrupt_line_b_o)
    else $error("interrupt b while disabled");
  a_idle_stable: assert property (idle && $past(idle) |->
    $stable(timer_out_a_o) && $stable(timer_out_b_o))
    else $error("wave moved while stopped");
  a_pwm_b_quiet: assert property (pwm_b && !comb && $past(ie_b) |->
    !$rose(interrupt_line_b_o))
    else $error("interrupt b in pwm mode");
endmodule

bind dpwm_timer dpwm_timer_chk u_chk (
  .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_pin_a_o,
  .port_pin_a_oe_o, .port_pin_b_oe_o, .timer_out_a_o, .timer_out_b_o,
  .interrupt_line_a_o, .interrupt_line_b_o
);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [4:0]  paddr     = 5'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [3:0]  port_in   = 4'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pa_o, pa_oe, pb_o, pb_oe, ta, tbw, ia, ib;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          hi_a, per_a, ed_a, hi_b, per_b, ed_b, ca, cb, hv;
  int          mdl[3] = '{0, 0, 0};
  int          dv[4]  = '{1, 8, 16, 64};

  dpwm_timer dut (.clk_sys_i, .nrst_i, .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port_pin_a_dout_i(port_in[0]), .port_pin_a_dir_i(port_in[1]),
    .port_pin_b_dout_i(port_in[2]), .port_pin_b_dir_i(port_in[3]),
    .port_pin_a_o(pa_o), .port_pin_a_oe_o(pa_oe), .port_pin_b_o(pb_o),
    .port_pin_b_oe_o(pb_oe), .timer_out_a_o(ta), .timer_out_b_o(tbw),
    .interrupt_line_a_o(ia), .interrupt_line_b_o(ib));
  dpwm_load la (.clk_sys_i, .pin_i(pa_o), .hi_o(hi_a), .per_o(per_a),
    .edges_o(ed_a));
  dpwm_load lb (.clk_sys_i, .pin_i(pb_o), .hi_o(hi_b), .per_o(per_b),
    .edges_o(ed_b));

  initial forever #20 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      results;
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    if (a == 5'h00) mdl[0] = d;
    if (a == 5'h04) mdl[1] = (d & 8'he3) | (mdl[1] & d & 8'h0c);
    if (a == 5'h08) mdl[2] = d & 8'h70;
  endtask
  task automatic rdchk(input logic [4:0] a);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    check(r, a < 5'h0c ? 32'(mdl[a >> 2]) : 32'h0);
    check({31'h0, e}, a > 5'h10 ? 32'h1 : 32'h0);
  endtask
  task automatic cfg(input logic [7:0] m, a, b, p, r);
    wr(dpwm_pkg::OFS_RUN, 8'h00);
    wr(dpwm_pkg::OFS_MODE, m);
    wr(dpwm_pkg::OFS_CMPA, a);
    wr(dpwm_pkg::OFS_CMPB, b);
    wr(dpwm_pkg::OFS_PIN, p);
    wr(dpwm_pkg::OFS_RUN, r);
  endtask
  task automatic meas(input logic b, input int ehi, input int eper);
    int e0, n;
    e0 = b ? ed_b : ed_a;
    n  = 0;
    while ((b ? ed_b : ed_a) < e0 + 2 && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40000) begin
      n_mismatch++;
      results;
    end else begin
      check(b ? hi_b : hi_a, ehi);
      check(b ? per_b : per_a, eper);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(3));
    port_in <= 4'($urandom);
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check({pa_oe, pa_o, pb_oe, pb_o}, {port_in[1:0], port_in[3:2]});
    for (int i = 0; i < 6; i++) rdchk(5'(i * 4));
    wr(dpwm_pkg::OFS_MODE, 8'($urandom));
    wr(dpwm_pkg::OFS_RUN, 8'h2f);
    wr(dpwm_pkg::OFS_PIN, 8'hff);
    wr(dpwm_pkg::OFS_CMPA, 8'h5a);
    wr(5'h14, 8'h33);
    for (int i = 0; i < 6; i++) rdchk(5'(i * 4));
    $display("test 1 finished");
    for (int c = 0; c < 4; c++) begin
      ca = $urandom_range(0, 7);
      hv = (ca + 1) * dv[c];
      cfg(8'(c << 2), 8'(ca), 8'h00, 8'h20, 8'h82);
      meas(1'b0, hv, 2 * hv);
      mdl[1] = mdl[1] | 8'h08;
      wr(dpwm_pkg::OFS_RUN, 8'h0e);
      rdchk(dpwm_pkg::OFS_RUN);
      check(ia, 1'b1);
      wr(dpwm_pkg::OFS_RUN, 8'h02);
      rdchk(dpwm_pkg::OFS_RUN);
      repeat (2) @(posedge clk_sys_i);
      check(ia, 1'b0);
    end
    $display("test 2 finished");
    for (int r = 0; r < 2; r++) begin
      cb = $urandom_range(1, r ? 127 : 255);
      cfg(r ? 8'h50 : 8'h40, 8'h00, 8'(cb), 8'h40, 8'h41);
      meas(1'b1, cb, r ? 128 : 256);
      check(ib, 1'b0);
    end
    $display("test 3 finished");
    ca = $urandom_range(0, 20);
    cb = ca + 1 + $urandom_range(0, 20);
    cfg(8'h00, 8'(ca), 8'(cb), 8'h30, 8'hc1);
    meas(1'b0, cb - ca, cb + 1);
    check(ib, 1'b1);
    $display("test 4 finished");
    ca = $urandom_range(0, 3);
    cb = $urandom_range(0, 3);
    cfg(8'h00, 8'(ca), 8'(cb), 8'h60, 8'he0);
    meas(1'b1, 2 * (cb + 1) * (ca + 1), 4 * (cb + 1) * (ca + 1));
    $display("test 5 finished");
    results;
  end
endmodule
